// file: hw/mcg_bank.sv
/*
 * Miscellaneous control and GPIO register bank with an APB slave port.
 * Assumes APB master on pclk; pins, brownout and package straps come from
 * outside the clock domain and are synchronised here.
 */
// Behaviour
// - A 30-bit takeover mask hands each set pin to the global I/O.
// - The takeover mask reads all zero after reset.
// - Thirty digital pins may be used as general purpose I/O.
// - Each taken-over pin has a direction bit for input or output.
// - A taken-over input pin shows its present level in a read bit.
// - A taken-over output pin drives the level of its value bit.
// - Each pin selects open-drain or push-pull drive.
// - Peripherals keep their own pin controls when not taken over.
// - A 2-bit package code is readable by firmware.
// - Low supply sets a brownout flag, pollable or interrupting.
// - The thermal sensor is off after reset and has an enable bit.
// - The thermal sensor feeds converter channel fourteen.
// - A factory count for the thermal channel is held, cleared at reset.
// - A mux register picks the function on each shared pin.
// - Share mode 01 closes switch one with pulses, 11 switch two.
// - Share control sets 8-bit period, duty and switch states.
`timescale 1ns/10ps
module mcg_bank (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins
    input  wire logic [29:0] pin_in,
    output logic      [29:0] pin_out,
    output logic      [29:0] pin_oe_n,
    // Peripheral side of the pins
    input  wire logic [29:0] periph_out,
    input  wire logic [29:0] periph_oe_n,
    output logic      [29:0] periph_in,
    // Analog and straps
    input  wire logic [1:0]  package_strap,
    input  wire logic        brownout_level,
    output logic             brownout_irq,
    output logic             thermal_enable,
    output logic [3:0]       thermal_channel,
    output logic [15:0]      pin_mux_select,
    output logic             share_switch_one_close,
    output logic             share_switch_two_close,
    output logic             share_pulse
);

    localparam int N = mcg_pkg::PIN_COUNT;

    logic [N-1:0]                 pin_takeover_enable;
    logic [N-1:0]                 pin_direction;
    logic [N-1:0]                 pin_open_drain;
    logic [N-1:0]                 pin_value;
    logic [N-1:0]                 pin_level;
    logic [mcg_pkg::PKG_W-1:0]    package_code;
    logic                         strap_taken;
    logic                         brownout_flag;
    logic                         brownout_ie;
    logic [mcg_pkg::COUNT_W-1:0]  thermal_factory_count;
    logic [mcg_pkg::MUX_W-1:0]    pin_mux;
    mcg_pkg::mcg_share_t          share_control_register;
    mcg_pkg::mcg_pin_drive_t      drive;
    logic [2:0]                   low_sync;
    logic [1:0]                   strap_s1;
    logic [1:0]                   strap_s2;
    logic                         wr_en;
    logic                         rd_en;
    logic                         mapped;
    logic                         next_brownout;
    logic                         pwm_run;

    // Address decode shared by read and write
    function automatic logic addr_hit(input logic [11:0] a,
                                      input logic [11:0] off);
        return a == off;
    endfunction

    // Zero-latency APB; every access completes in its access cycle
    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && penable && !pwrite;

    always_comb
    begin
        mapped = addr_hit(paddr, mcg_pkg::OFF_PACKAGE_CODE)
              || addr_hit(paddr, mcg_pkg::OFF_PIN_TAKEOVER)
              || addr_hit(paddr, mcg_pkg::OFF_PIN_DIRECTION)
              || addr_hit(paddr, mcg_pkg::OFF_PIN_OPEN_DRAIN)
              || addr_hit(paddr, mcg_pkg::OFF_PIN_VALUE)
              || addr_hit(paddr, mcg_pkg::OFF_PIN_LEVEL)
              || addr_hit(paddr, mcg_pkg::OFF_STATUS)
              || addr_hit(paddr, mcg_pkg::OFF_THERMAL_CTRL)
              || addr_hit(paddr, mcg_pkg::OFF_THERMAL_COUNT)
              || addr_hit(paddr, mcg_pkg::OFF_PIN_MUX)
              || addr_hit(paddr, mcg_pkg::OFF_SHARE_CTRL);
    end

    // Unmapped addresses answer with an error
    assign pslverr = psel && penable && !mapped;

    // Pin level synchroniser
    mcg_pin_sync #(
        .WIDTH    (N)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pin_in),
        .sync_out (pin_level)
    );

    // Brownout and strap synchronisers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_sync <= 3'h0;
        end
        else
        begin
            low_sync <= {low_sync[1:0], brownout_level};
        end
    end

    // Strap flops without reset, filled while reset is held
    always_ff @(posedge pclk)
    begin
        strap_s1 <= package_strap;
        strap_s2 <= strap_s1;
    end

    // Takeover mask, cleared at reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_takeover_enable <= mcg_pkg::PIN_RESET;
        else if (wr_en && addr_hit(paddr, mcg_pkg::OFF_PIN_TAKEOVER))
            pin_takeover_enable <= pwdata[N-1:0];
    end

    // Direction, drive style and output value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_direction  <= mcg_pkg::PIN_RESET;
            pin_open_drain <= mcg_pkg::PIN_RESET;
            pin_value      <= mcg_pkg::PIN_RESET;
        end
        else if (wr_en)
        begin
            if (addr_hit(paddr, mcg_pkg::OFF_PIN_DIRECTION))
                pin_direction <= pwdata[N-1:0];
            if (addr_hit(paddr, mcg_pkg::OFF_PIN_OPEN_DRAIN))
                pin_open_drain <= pwdata[N-1:0];
            if (addr_hit(paddr, mcg_pkg::OFF_PIN_VALUE))
                pin_value <= pwdata[N-1:0];
        end
    end

    // Package code: strap caught after reset, firmware may rewrite
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            package_code <= mcg_pkg::PKG_RESET;
            strap_taken  <= 1'b0;
        end
        else if (!strap_taken)
        begin
            package_code <= strap_s2;
            strap_taken  <= 1'b1;
        end
        else if (wr_en && addr_hit(paddr, mcg_pkg::OFF_PACKAGE_CODE))
            package_code <= pwdata[mcg_pkg::PKG_W-1:0];
    end

    // Brownout flag: set wins over write-one-to-clear
    always_comb
    begin
        next_brownout = brownout_flag;
        if (wr_en && addr_hit(paddr, mcg_pkg::OFF_STATUS)
            && pwdata[mcg_pkg::BROWNOUT_BIT])
            next_brownout = 1'b0;
        if (low_sync[2])
            next_brownout = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            brownout_flag <= 1'b0;
            brownout_ie   <= 1'b0;
        end
        else
        begin
            brownout_flag <= next_brownout;
            if (wr_en && addr_hit(paddr, mcg_pkg::OFF_STATUS))
                brownout_ie <= pwdata[mcg_pkg::BROWNOUT_IE];
        end
    end

    assign brownout_irq = brownout_flag && brownout_ie;

    // Thermal enable, off after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            thermal_enable <= 1'b0;
        else if (wr_en && addr_hit(paddr, mcg_pkg::OFF_THERMAL_CTRL))
            thermal_enable <= pwdata[mcg_pkg::THERMAL_EN_BIT];
    end

    assign thermal_channel = mcg_pkg::THERMAL_CHANNEL;

    // Factory count, cleared at reset, writable by any APB write to its offset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            thermal_factory_count <= mcg_pkg::THERMAL_RESET;
        else if (wr_en && addr_hit(paddr, mcg_pkg::OFF_THERMAL_COUNT))
            thermal_factory_count <= pwdata[mcg_pkg::COUNT_W-1:0];
    end

    // Pin mux and share control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_mux                <= mcg_pkg::MUX_RESET;
            share_control_register <= '0;
        end
        else if (wr_en)
        begin
            if (addr_hit(paddr, mcg_pkg::OFF_PIN_MUX))
                pin_mux <= pwdata[mcg_pkg::MUX_W-1:0];
            if (addr_hit(paddr, mcg_pkg::OFF_SHARE_CTRL))
                share_control_register <= {pwdata[23:8], pwdata[3:0]};
        end
    end

    assign pin_mux_select = pin_mux;

    // Share mode decode
    always_comb
    begin
        share_switch_one_close = 1'b0;
        share_switch_two_close = 1'b0;
        pwm_run                = 1'b0;
        unique case (share_control_register.mode)
            mcg_pkg::MCG_SHARE_OFF_A,
            mcg_pkg::MCG_SHARE_OFF_B: ;
            mcg_pkg::MCG_SHARE_PWM:
            begin
                share_switch_one_close = 1'b1;
                pwm_run                = 1'b1;
            end
            mcg_pkg::MCG_SHARE_ANALOG:
                share_switch_two_close = 1'b1;
        endcase
    end

    mcg_share_pwm u_pwm (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (pwm_run),
        .period  (share_control_register.period),
        .duty    (share_control_register.duty),
        .pulse   (share_pulse)
    );

    // Per-pin drive: peripheral or global control
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pin
            always_comb
            begin
                if (!pin_takeover_enable[i])
                begin
                    drive.out[i]  = periph_out[i];
                    drive.oe_n[i] = periph_oe_n[i];
                end
                else if (!pin_direction[i])
                begin
                    drive.out[i]  = 1'b0;
                    drive.oe_n[i] = 1'b1;
                end
                else if (pin_open_drain[i])
                begin
                    drive.out[i]  = 1'b0;
                    drive.oe_n[i] = pin_value[i];
                end
                else
                begin
                    drive.out[i]  = pin_value[i];
                    drive.oe_n[i] = 1'b0;
                end
            end
        end
    endgenerate

    // Registered pin outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out  <= mcg_pkg::PIN_RESET;
            pin_oe_n <= ~mcg_pkg::PIN_RESET;
        end
        else
        begin
            pin_out  <= drive.out;
            pin_oe_n <= drive.oe_n;
        end
    end

    assign periph_in = pin_level;

    // Read data, registered at the edge that ends the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (1'b1)
                addr_hit(paddr, mcg_pkg::OFF_PACKAGE_CODE):
                    prdata <= {30'h0, package_code};
                addr_hit(paddr, mcg_pkg::OFF_PIN_TAKEOVER):
                    prdata <= {2'h0, pin_takeover_enable};
                addr_hit(paddr, mcg_pkg::OFF_PIN_DIRECTION):
                    prdata <= {2'h0, pin_direction};
                addr_hit(paddr, mcg_pkg::OFF_PIN_OPEN_DRAIN):
                    prdata <= {2'h0, pin_open_drain};
                addr_hit(paddr, mcg_pkg::OFF_PIN_VALUE):
                    prdata <= {2'h0, pin_value};
                addr_hit(paddr, mcg_pkg::OFF_PIN_LEVEL):
                    prdata <= {2'h0, pin_level};
                addr_hit(paddr, mcg_pkg::OFF_STATUS):
                    prdata <= {30'h0, brownout_ie, brownout_flag};
                addr_hit(paddr, mcg_pkg::OFF_THERMAL_CTRL):
                    prdata <= {31'h0, thermal_enable};
                addr_hit(paddr, mcg_pkg::OFF_THERMAL_COUNT):
                    prdata <= {20'h0, thermal_factory_count};
                addr_hit(paddr, mcg_pkg::OFF_PIN_MUX):
                    prdata <= {16'h0, pin_mux};
                addr_hit(paddr, mcg_pkg::OFF_SHARE_CTRL):
                    prdata <= {8'h0, share_control_register[19:4], 4'h0,
                               share_control_register[3:0]};
                default:
                    prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule // mcg_bank

// file: hw/mcg_pin_sync.sv
/*
 * Two-stage synchroniser for a vector of pin levels.
 * Assumes inputs are asynchronous to pclk.
 */
`timescale 1ns/10ps
module mcg_pin_sync #(
    parameter int WIDTH = 30
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // Two flops, first read only by second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage_one <= '0;
            sync_out  <= '0;
        end
        else
        begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule // mcg_pin_sync

// file: hw/mcg_pkg.sv
/*
 * Shared constants and types for the miscellaneous control and GPIO bank:
 * register offsets, reset values, share-mode codes and pin carrier types.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package mcg_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_PACKAGE_CODE   = 12'h000;
    localparam logic [11:0] OFF_PIN_TAKEOVER   = 12'h004;
    localparam logic [11:0] OFF_PIN_DIRECTION  = 12'h008;
    localparam logic [11:0] OFF_PIN_OPEN_DRAIN = 12'h00C;
    localparam logic [11:0] OFF_PIN_VALUE      = 12'h010;
    localparam logic [11:0] OFF_PIN_LEVEL      = 12'h014;
    localparam logic [11:0] OFF_STATUS         = 12'h018;
    localparam logic [11:0] OFF_THERMAL_CTRL   = 12'h01C;
    localparam logic [11:0] OFF_THERMAL_COUNT  = 12'h020;
    localparam logic [11:0] OFF_PIN_MUX        = 12'h024;
    localparam logic [11:0] OFF_SHARE_CTRL     = 12'h028;

    // Widths and field positions
    localparam int PIN_COUNT      = 30;
    localparam int PKG_W          = 2;
    localparam int COUNT_W        = 12;
    localparam int MUX_W          = 16;
    localparam int BROWNOUT_BIT   = 0;
    localparam int BROWNOUT_IE    = 1;
    localparam int THERMAL_EN_BIT = 0;
    localparam int SHARE_MODE_LSB = 0;
    localparam int SHARE_TEST_LSB = 2;
    localparam int SHARE_PRD_LSB  = 8;
    localparam int SHARE_DUTY_LSB = 16;

    // Reset values
    localparam logic [PIN_COUNT-1:0] PIN_RESET      = 30'h0000_0000;
    localparam logic [PKG_W-1:0]     PKG_RESET      = 2'h0;
    localparam logic [COUNT_W-1:0]   THERMAL_RESET  = 12'h000;
    localparam logic [MUX_W-1:0]     MUX_RESET      = 16'h0000;
    localparam logic [7:0]           BYTE_RESET     = 8'h00;

    // Thermal sensor converter channel
    localparam logic [3:0] THERMAL_CHANNEL = 4'hE;

    // Share mode codes
    typedef enum logic [1:0] {
        MCG_SHARE_OFF_A  = 2'b00,
        MCG_SHARE_PWM    = 2'b01,
        MCG_SHARE_OFF_B  = 2'b10,
        MCG_SHARE_ANALOG = 2'b11
    } mcg_share_mode_t;

    // Share control word
    typedef struct packed {
        logic [7:0]      duty;
        logic [7:0]      period;
        logic [1:0]      test;
        mcg_share_mode_t mode;
    } mcg_share_t;

    // Pin drive bundle, oe low while the pin is driven
    typedef struct packed {
        logic [PIN_COUNT-1:0] out;
        logic [PIN_COUNT-1:0] oe_n;
    } mcg_pin_drive_t;

endpackage

// file: hw/mcg_share_pwm.sv
/*
 * Eight-bit pulse generator for the current-share bus.
 * Assumes period and duty are held steady by the register bank.
 */
`timescale 1ns/10ps
module mcg_share_pwm (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       run,
    input  wire logic [7:0] period,
    input  wire logic [7:0] duty,
    // Output
    output logic            pulse
);

    logic [7:0] count;

    // Period counter, held at zero when stopped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= mcg_pkg::BYTE_RESET;
        else if (!run || count >= period)
            count <= mcg_pkg::BYTE_RESET;
        else
            count <= count + 8'h01;
    end

    // Registered pulse output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pulse <= 1'b0;
        else
            pulse <= run && (count < duty);
    end

endmodule // mcg_share_pwm

// file: tb/mcg_bank_props.sv
/* Checker bound into the control and GPIO bank.
   Assumes one pclk domain, active-low presetn. */
`timescale 1ns/10ps
module mcg_bank_props (
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // Pins and controls
    input wire logic [29:0] pin_out,
    input wire logic [29:0] pin_oe_n,
    input wire logic        brownout_level,
    input wire logic        brownout_irq,
    input wire logic        thermal_enable,
    input wire logic [3:0]  thermal_channel,
    input wire logic [15:0] pin_mux_select,
    input wire logic        share_switch_one_close,
    input wire logic        share_switch_two_close,
    input wire logic        share_pulse
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic        wr;
    logic [29:0] tk, dir, od, val, exp_oe, exp_out, out_mask;
    logic        ie;
    logic [1:0]  mode;
    logic [1:0]  calm;
    // Completed write and expected pin drive
    assign wr       = psel && penable && pwrite && pready;
    assign exp_oe   = ~dir | (od & val);
    assign exp_out  = dir & val & ~od;
    assign out_mask = tk & ~(dir & od & val);
    // Shadow pin registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tk  <= '0;
            dir <= '0;
            od  <= '0;
            val <= '0;
        end
        else if (wr)
        begin
            case (paddr)
                mcg_pkg::OFF_PIN_TAKEOVER:   tk  <= pwdata[29:0];
                mcg_pkg::OFF_PIN_DIRECTION:  dir <= pwdata[29:0];
                mcg_pkg::OFF_PIN_OPEN_DRAIN: od  <= pwdata[29:0];
                mcg_pkg::OFF_PIN_VALUE:      val <= pwdata[29:0];
                default: ;
            endcase
        end
    end
    // Shadow brownout enable and share mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ie   <= 1'b0;
            mode <= 2'h0;
        end
        else if (wr && paddr == mcg_pkg::OFF_STATUS)
            ie <= pwdata[1];
        else if (wr && paddr == mcg_pkg::OFF_SHARE_CTRL)
            mode <= pwdata[1:0];
    end
    // Cycles since a pin register write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            calm <= 2'h0;
        else if (wr && paddr inside {[12'h004:12'h010]})
            calm <= 2'h0;
        else if (calm != 2'h3)
            calm <= calm + 2'h1;
    end

    sequence s_wr(logic [11:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    sequence s_rd(logic [11:0] a);
        psel && penable && !pwrite && paddr == a;
    endsequence

    property p_mask_read;
        s_rd(mcg_pkg::OFF_PIN_TAKEOVER) |-> prdata == {2'h0, tk};
    endproperty
    property p_pin_oe;
        calm == 2'h3 |-> ((pin_oe_n ^ exp_oe) & tk) == 30'h0;
    endproperty
    property p_pin_out;
        calm == 2'h3 |-> ((pin_out ^ exp_out) & out_mask) == 30'h0;
    endproperty
    property p_brown;
        (brownout_level && ie)[*5] |-> brownout_irq;
    endproperty
    property p_no_irq;
        !ie |-> !brownout_irq;
    endproperty
    property p_thermal;
        s_wr(mcg_pkg::OFF_THERMAL_CTRL) |=>
            thermal_enable == $past(pwdata[0]);
    endproperty
    property p_channel;
        thermal_channel == 4'hE;
    endproperty
    property p_mux;
        s_wr(mcg_pkg::OFF_PIN_MUX) |=> pin_mux_select == $past(pwdata[15:0]);
    endproperty
    property p_switch;
        s_wr(mcg_pkg::OFF_SHARE_CTRL) |=>
            share_switch_one_close == ($past(pwdata[1:0]) == 2'b01) &&
            share_switch_two_close == ($past(pwdata[1:0]) == 2'b11);
    endproperty
    property p_no_pulse;
        (mode != 2'b01)[*4] |-> !share_pulse;
    endproperty

    a_mask_read: assert property (p_mask_read)
        else $error("Mask read wrong");
    a_pin_oe: assert property (p_pin_oe)
        else $error("Pin enable wrong");
    a_pin_out: assert property (p_pin_out)
        else $error("Pin level wrong");
    a_brown: assert property (p_brown)
        else $error("Irq missing");
    a_no_irq: assert property (p_no_irq)
        else $error("Irq while masked");
    a_thermal: assert property (p_thermal)
        else $error("Thermal enable not updated");
    a_channel: assert property (p_channel)
        else $error("Thermal channel wrong");
    a_mux: assert property (p_mux)
        else $error("Mux wrong");
    a_switch: assert property (p_switch)
        else $error("Switch wrong");
    a_no_pulse: assert property (p_no_pulse)
        else $error("Stray pulse");
endmodule // mcg_bank_props

bind mcg_bank mcg_bank_props u_mcg_bank_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pin_out, .pin_oe_n, .brownout_level, .brownout_irq,
    .thermal_enable, .thermal_channel, .pin_mux_select,
    .share_switch_one_close, .share_switch_two_close, .share_pulse
);

// file: tb/testbench.sv
/* APB bench for the control and GPIO bank.
   Assumes the bound property checker. */
`timescale 1ns/10ps
module testbench;
    localparam logic [29:0] P_OUT = 30'h2AAA_AAAA;
    localparam logic [29:0] P_OEN = 30'h1555_5555;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, rerr;
    logic [29:0] pin_in, pin_out, pin_oe_n, periph_in;
    logic [1:0]  package_strap;
    logic        brownout_level, brownout_irq, thermal_enable;
    logic [3:0]  thermal_channel;
    logic [15:0] pin_mux_select;
    logic        sw_one, sw_two, share_pulse;
    int          err_total, tests_run, cycles, highs;

    mcg_bank u_mcg_bank (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n, .periph_out(P_OUT),
        .periph_oe_n(P_OEN), .periph_in, .package_strap, .brownout_level,
        .brownout_irq, .thermal_enable, .thermal_channel, .pin_mux_select,
        .share_switch_one_close(sw_one), .share_switch_two_close(sw_two),
        .share_pulse
    );

    // Clock and hang guard
    always #10 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic is_wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= is_wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge pclk);
        end
        rd = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic conclude();
        $display("Counts: %0d compared, %0d mismatched", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 12'h0; pwdata = 32'h0; pin_in = 30'h0;
        package_strap = 2'h1; brownout_level = 0;
        err_total = 0; tests_run = 0; cycles = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of every register
        for (int a = 4; a <= 40; a += 4)
            rd_check(a[11:0], 32'h0);
        rd_check(mcg_pkg::OFF_PACKAGE_CODE, 32'h1);
        check({31'h0, thermal_enable}, 32'h0);
        wr(mcg_pkg::OFF_PACKAGE_CODE, 32'h2);
        rd_check(mcg_pkg::OFF_PACKAGE_CODE, 32'h2);
        $display("Test reset values done");
        // Full mask, then an unmapped access leaves it intact
        wr(mcg_pkg::OFF_PIN_TAKEOVER, 32'hFFFF_FFFF);
        rd_check(mcg_pkg::OFF_PIN_TAKEOVER, 32'h3FFF_FFFF);
        wr(12'h100, 32'h0);
        check({31'h0, rerr}, 32'h1);
        rd_check(12'h100, 32'h0);
        rd_check(mcg_pkg::OFF_PIN_TAKEOVER, 32'h3FFF_FFFF);
        $display("Test mask and unmapped done");
        // Mixed push-pull, open-drain and input pins
        wr(mcg_pkg::OFF_PIN_TAKEOVER, 32'h1F);
        wr(mcg_pkg::OFF_PIN_DIRECTION, 32'h0F);
        wr(mcg_pkg::OFF_PIN_OPEN_DRAIN, 32'h0C);
        wr(mcg_pkg::OFF_PIN_VALUE, 32'h09);
        pin_in <= 30'h1234_5678;
        repeat (4) @(posedge pclk);
        check({2'h0, pin_oe_n}, {2'h0, (P_OEN & ~30'h1F) | 30'h18});
        check({2'h0, pin_out & ~30'h08}, {2'h0, (P_OUT & ~30'h1F) | 30'h01});
        rd_check(mcg_pkg::OFF_PIN_LEVEL, 32'h1234_5678);
        check({2'h0, periph_in}, 32'h1234_5678);
        rd_check(mcg_pkg::OFF_PIN_OPEN_DRAIN, 32'h0C);
        wr(mcg_pkg::OFF_PIN_TAKEOVER, 32'h0);
        repeat (4) @(posedge pclk);
        check({2'h0, pin_oe_n}, {2'h0, P_OEN});
        check({2'h0, pin_out}, {2'h0, P_OUT});
        $display("Test pins done");
        // Brownout flag, interrupt, clear and mask
        wr(mcg_pkg::OFF_STATUS, 32'h2);
        brownout_level <= 1'b1;
        repeat (5) @(posedge pclk);
        check({31'h0, brownout_irq}, 32'h1);
        brownout_level <= 1'b0;
        rd_check(mcg_pkg::OFF_STATUS, 32'h3);
        wr(mcg_pkg::OFF_STATUS, 32'h3);
        rd_check(mcg_pkg::OFF_STATUS, 32'h2);
        wr(mcg_pkg::OFF_STATUS, 32'h0);
        brownout_level <= 1'b1;
        repeat (5) @(posedge pclk);
        check({31'h0, brownout_irq}, 32'h0);
        rd_check(mcg_pkg::OFF_STATUS, 32'h1);
        brownout_level <= 1'b0;
        rd_check(mcg_pkg::OFF_PACKAGE_CODE, 32'h2);
        $display("Test brownout done");
        // Thermal controls, factory count, mux
        wr(mcg_pkg::OFF_THERMAL_CTRL, 32'h1);
        @(posedge pclk);
        check({31'h0, thermal_enable}, 32'h1);
        check({28'h0, thermal_channel}, 32'hE);
        wr(mcg_pkg::OFF_THERMAL_COUNT, 32'hFFFF_FABC);
        rd_check(mcg_pkg::OFF_THERMAL_COUNT, 32'h0ABC);
        wr(mcg_pkg::OFF_PIN_MUX, 32'h1234_A5C3);
        rd_check(mcg_pkg::OFF_PIN_MUX, 32'hA5C3);
        check({16'h0, pin_mux_select}, 32'hA5C3);
        $display("Test thermal and mux done");
        // Every share mode, period 4 and duty 2
        for (int m = 0; m < 4; m++)
        begin
            wr(mcg_pkg::OFF_SHARE_CTRL, 32'h0002_0400 | m);
            rd_check(mcg_pkg::OFF_SHARE_CTRL, 32'h0002_0400 | m);
            check({30'h0, sw_two, sw_one}, m == 1 ? 1 : m == 3 ? 2 : 0);
            repeat (3) @(posedge pclk);
            highs = 0;
            repeat (20)
            begin
                @(posedge pclk);
                highs += (share_pulse === 1'b1);
            end
            check(highs, m == 1 ? 8 : 0);
        end
        $display("Test share modes done");
        conclude();
    end
endmodule // testbench
